// ### rtl/sdtx_pkg.sv
package sdtx_pkg;

  // Channel and word geometry.
  localparam int SDTX_CHANNELS = 4;
  localparam int SDTX_WORD_W = 16;
  localparam int SDTX_CODE_W = 20;
  localparam int SDTX_CHAR_W = 10;

  // Start-up comma run: the channel forces idle words while the count is at or below this value.
  localparam logic [2:0] SDTX_SYNC_LAST = 3'h3;
  localparam logic [2:0] SDTX_SYNC_STEP = 3'h1;
  localparam logic [2:0] SDTX_SYNC_RESET = 3'h0;

  // Reset values of the output word and of the running disparity (0 = negative).
  localparam logic [19:0] SDTX_CODE_RESET = 20'h0_0000;
  localparam logic SDTX_DISP_RESET = 1'b0;

  // Special characters as byte values (high three bits y, low five bits x).
  localparam logic [7:0] SDTX_K28_5 = 8'hbc;
  localparam logic [7:0] SDTX_D5_6 = 8'hc5;
  localparam logic [7:0] SDTX_D16_2 = 8'h50;
  localparam logic [7:0] SDTX_K23_7 = 8'hf7;
  localparam logic [7:0] SDTX_K30_7 = 8'hfe;

  // Sub-block values that change the code tables.
  localparam logic [4:0] SDTX_X_K28 = 5'h1c;
  localparam logic [4:0] SDTX_X_D7 = 5'h07;
  localparam logic [2:0] SDTX_Y_3 = 3'h3;
  localparam logic [2:0] SDTX_Y_7 = 3'h7;
  localparam logic [4:0] SDTX_X_ALT_N0 = 5'h11;
  localparam logic [4:0] SDTX_X_ALT_N1 = 5'h12;
  localparam logic [4:0] SDTX_X_ALT_N2 = 5'h14;
  localparam logic [4:0] SDTX_X_ALT_P0 = 5'h0b;
  localparam logic [4:0] SDTX_X_ALT_P1 = 5'h0d;
  localparam logic [4:0] SDTX_X_ALT_P2 = 5'h0e;

  // Six-bit codes for negative disparity, written abcdei with a as the top bit.
  localparam logic [5:0] SDTX_6B_TAB [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b
  };
  localparam logic [5:0] SDTX_6B_K28 = 6'h0f;
  // One bit per x value: set where the six-bit code is unbalanced.
  localparam logic [31:0] SDTX_6B_UNBAL = 32'he981_8117;

  // Four-bit codes for negative disparity, written fghj with f as the top bit.
  localparam logic [3:0] SDTX_4B_TAB [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he
  };
  localparam logic [3:0] SDTX_4B_ALT = 4'h7;
  localparam logic [7:0] SDTX_4B_UNBAL = 8'h91;

  // What a word slot carries.
  typedef enum logic [1:0] {
    SDTX_IDLE,
    SDTX_DATA,
    SDTX_EXTEND,
    SDTX_ERROR
  } sdtx_kind_t;

  // Start-up phase of a channel.
  typedef enum logic {
    SDTX_ST_SYNC,
    SDTX_ST_RUN
  } sdtx_start_t;

  // One channel's word slot as presented by the protocol device.
  typedef struct packed {
    logic frame_valid;
    logic send_fault_flag;
    logic [15:0] send_word_bus;
  } sdtx_word_in_t;

  // One channel's encoded word; code bit 0 is the first bit on the line.
  typedef struct packed {
    sdtx_kind_t kind;
    logic disp_pos;
    logic [19:0] code;
  } sdtx_code_out_t;

endpackage

// ### rtl/sdtx_enc8b10b.sv
`timescale 1ns/10ps
// Encodes one byte into a ten-bit character, chaining the running disparity.
module sdtx_enc8b10b
  import sdtx_pkg::*;
(
  input wire logic [7:0] data_byte,
  input wire logic is_control,
  input wire logic disp_in,
  output logic [9:0] code_char,
  output logic disp_out
);

  logic [4:0] x_val;
  logic [2:0] y_val;
  logic [5:0] six;
  logic [3:0] four;
  logic six_unbal;
  logic four_unbal;
  logic disp_mid;
  logic use_alt;
  logic is_k28;

  // Only K28.y, K23.7 and K30.7 are ever requested, so other control codes are not special-cased.
  always_comb begin
    x_val = data_byte[4:0];
    y_val = data_byte[7:5];
    is_k28 = is_control && (x_val == SDTX_X_K28);
    six = is_k28 ? SDTX_6B_K28 : SDTX_6B_TAB[x_val];
    six_unbal = is_k28 || SDTX_6B_UNBAL[x_val];
    // D.7 is balanced yet still alternates with disparity.
    if (disp_in && (six_unbal || (!is_k28 && x_val == SDTX_X_D7))) begin
      six = ~six;
    end
    disp_mid = disp_in ^ six_unbal;
    // The alternate y=7 form avoids a run of five equal bits across the sub-blocks.
    use_alt = (y_val == SDTX_Y_7) && (is_control ||
              (!disp_mid && (x_val == SDTX_X_ALT_N0 || x_val == SDTX_X_ALT_N1 ||
                             x_val == SDTX_X_ALT_N2)) ||
              (disp_mid && (x_val == SDTX_X_ALT_P0 || x_val == SDTX_X_ALT_P1 ||
                            x_val == SDTX_X_ALT_P2)));
    four = use_alt ? SDTX_4B_ALT : SDTX_4B_TAB[y_val];
    four_unbal = SDTX_4B_UNBAL[y_val];
    if (disp_mid && (four_unbal || y_val == SDTX_Y_3)) begin
      four = ~four;
    end else if (is_k28 && !disp_mid && !four_unbal) begin
      four = ~four;
    end
    disp_out = disp_mid ^ four_unbal;
    // Bit a goes to bit 0 so that it leaves the serializer first.
    for (int i = 0; i < 6; i++) begin
      code_char[i] = six[5 - i];
    end
    for (int j = 0; j < 4; j++) begin
      code_char[6 + j] = four[3 - j];
    end
  end

endmodule

// ### rtl/sdtx_word_port.sv
`timescale 1ns/10ps
// Behaviour
// [R01] The protocol device raises frame-valid with the first preamble word and holds it for the whole frame.
// [R02] The protocol device drops frame-valid before the first word-clock edge after the last word of a frame.
// [R03] Frame-valid and the fault flag both high make the slot an error propagation word.
// [R04] Fault flag high with frame-valid low makes the slot a carrier extension word.
// [R05] Frame-valid high with the fault flag low makes the slot normal payload data.
// [R06] The 16-bit transmit word is captured into the input register on every rising word-clock edge.
// [R07] The factory test select input is left open or low and has no function.
// [R08] Each of the four channels has its own inputs and runs independently of the others.
// [R09] With both qualifiers low the slot becomes one idle word, K28.5 then D5.6 or D16.2.
// [R10] Carrier extension is sent as two K23.7 characters in one 20-bit word.
// [R11] Error propagation is sent as two K30.7 characters in one 20-bit word.
// [R12] The encoded word leaves least significant bit first, starting with bit zero.
// [R13] Between frames the protocol device holds both qualifiers low so that idle fills the gap.
module sdtx_word_port
  import sdtx_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input sdtx_word_in_t [3:0] chan_in,
  input wire logic [3:0] factory_test_select,
  output sdtx_code_out_t [3:0] chan_out,
  output logic [3:0] frame_fault,
  output logic [3:0] link_ready
);

  // The clock is the send word clock; the protocol device drives its words aligned
  // to it, so the slot inputs are same-domain and need no synchroniser.
  // The factory test select inputs are deliberately not read by any logic.
  // They reach no flip-flop at all, so a floating pin cannot disturb a channel; a later
  // test feature would need its own two-stage synchroniser before any logic reads it.
  // Latency is two word clocks: one edge into the input register and one into the output
  // word register, so every slot kind leaves the block at the same time.

  // Each channel keeps its own input register, start-up run, disparity and fault marker;
  // nothing is shared, so a frame on one lane never changes the code words of another.
  // [R08] Per-channel copies
  for (genvar ch = 0; ch < SDTX_CHANNELS; ch++) begin : g_chan

    sdtx_word_in_t in_q;
    sdtx_start_t start_q;
    logic [2:0] sync_cnt_q;
    sdtx_kind_t kind_d;
    logic [7:0] lo_byte;
    logic [7:0] hi_byte;
    logic lo_ctrl;
    logic hi_ctrl;
    logic [9:0] lo_char;
    logic [9:0] hi_char;
    logic disp_lo;
    logic disp_hi;
    sdtx_code_out_t out_q;
    sdtx_code_out_t out_d;
    logic fault_q;
    logic ready_q;

    // [R06] Input word capture
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        in_q <= '0;
      end else begin
        in_q <= chan_in[ch];
      end
    end

    // A short run of idle words follows reset so the far receiver can find commas
    // before any payload; inputs presented during this run are dropped, not delayed.
    // The counter stops once the run ends; only a new reset starts another comma run,
    // so a long gap between frames does not repeat it.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        start_q <= SDTX_ST_SYNC;
        sync_cnt_q <= SDTX_SYNC_RESET;
      end else begin
        case (start_q)
          SDTX_ST_SYNC: begin
            sync_cnt_q <= sync_cnt_q + SDTX_SYNC_STEP;
            if (sync_cnt_q == SDTX_SYNC_LAST) begin
              start_q <= SDTX_ST_RUN;
            end
          end
          SDTX_ST_RUN: begin
            sync_cnt_q <= sync_cnt_q;
          end
          default: begin
            start_q <= SDTX_ST_SYNC;
            sync_cnt_q <= SDTX_SYNC_RESET;
          end
        endcase
      end
    end

    // Slot decode from the two qualifiers of the captured word.
    // During the start-up run every slot decodes as idle, which keeps the comma pattern
    // intact even if the protocol device starts a frame too early.
    always_comb begin
      kind_d = SDTX_IDLE;
      if (start_q == SDTX_ST_RUN) begin
        case ({in_q.frame_valid, in_q.send_fault_flag})
          // [R03] Error propagation slot
          2'b11: kind_d = SDTX_ERROR;
          // [R04] Carrier extension slot
          2'b01: kind_d = SDTX_EXTEND;
          // [R05] Normal data slot
          2'b10: kind_d = SDTX_DATA;
          // [R13] Gap fills idle
          default: kind_d = SDTX_IDLE;
        endcase
      end
    end

    // Byte selection per slot kind; the low byte is encoded first.
    // Kind is decided before the bytes, so the encoders see a control flag only for the
    // special characters and never for payload, whatever the payload bits hold.
    always_comb begin
      lo_byte = SDTX_K28_5;
      hi_byte = SDTX_D16_2;
      lo_ctrl = 1'b1;
      hi_ctrl = 1'b0;
      case (kind_d)
        SDTX_DATA: begin
          lo_byte = in_q.send_word_bus[7:0];
          hi_byte = in_q.send_word_bus[15:8];
          lo_ctrl = 1'b0;
          hi_ctrl = 1'b0;
        end
        // [R10] Two K23.7 characters
        SDTX_EXTEND: begin
          lo_byte = SDTX_K23_7;
          hi_byte = SDTX_K23_7;
          lo_ctrl = 1'b1;
          hi_ctrl = 1'b1;
        end
        // [R11] Two K30.7 characters
        SDTX_ERROR: begin
          lo_byte = SDTX_K30_7;
          hi_byte = SDTX_K30_7;
          lo_ctrl = 1'b1;
          hi_ctrl = 1'b1;
        end
        // [R09] Idle word choice
        default: begin
          // Positive disparity takes D5.6 so the idle word ends negative either way.
          lo_byte = SDTX_K28_5;
          hi_byte = out_q.disp_pos ? SDTX_D5_6 : SDTX_D16_2;
          lo_ctrl = 1'b1;
          hi_ctrl = 1'b0;
        end
      endcase
    end

    // The two encoders chain disparity low byte to high byte within one word.
    // Both are combinational, so the whole word and its disparity settle in one word
    // clock; this chain is what limits the clock rate of the path.
    sdtx_enc8b10b u_enc_lo (
      .data_byte(lo_byte),
      .is_control(lo_ctrl),
      .disp_in(out_q.disp_pos),
      .code_char(lo_char),
      .disp_out(disp_lo)
    );

    sdtx_enc8b10b u_enc_hi (
      .data_byte(hi_byte),
      .is_control(hi_ctrl),
      .disp_in(disp_lo),
      .code_char(hi_char),
      .disp_out(disp_hi)
    );

    // [R12] First character in low bits
    always_comb begin
      out_d.kind = kind_d;
      out_d.disp_pos = disp_hi;
      out_d.code = {hi_char, lo_char};
    end

    // Output word register; it also holds the running disparity for the next word.
    // Keeping the disparity beside the code makes the idle choice and the next word's
    // first character use exactly the disparity that left on the line.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        out_q.kind <= SDTX_IDLE;
        out_q.disp_pos <= SDTX_DISP_RESET;
        out_q.code <= SDTX_CODE_RESET;
      end else begin
        out_q <= out_d;
      end
    end

    // [R01] Fault marker spans frame
    // [R02] Frame end clears marker
    // Error slots only occur with frame-valid high, so setting and clearing never collide.
    // The marker is a level for the protocol device's bookkeeping; it does not say which
    // word was bad, only that the frame in flight carries an error.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        fault_q <= 1'b0;
      end else if (kind_d == SDTX_ERROR) begin
        fault_q <= 1'b1;
      end else if (!in_q.frame_valid) begin
        fault_q <= 1'b0;
      end
    end

    // Ready marks the first word that follows the captured inputs rather than start-up idle.
    // It rises one edge after the run state is entered, together with the first word
    // that comes from the captured inputs.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        ready_q <= 1'b0;
      end else begin
        ready_q <= (start_q == SDTX_ST_RUN);
      end
    end

    assign chan_out[ch] = out_q;
    assign frame_fault[ch] = fault_q;
    assign link_ready[ch] = ready_q;

  end

endmodule

// ### testbench/sdtx_word_port_chk.sv
`timescale 1ns/10ps
// Watches the pins; a slot sampled at one edge shows on chan_out two samples later.
module sdtx_word_port_chk
  import sdtx_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input sdtx_word_in_t [3:0] chan_in,
  input wire logic [3:0] factory_test_select,
  input sdtx_code_out_t [3:0] chan_out,
  input wire logic [3:0] frame_fault,
  input wire logic [3:0] link_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Channel zero; link_ready keeps the start-up comma run out of the data, error, extend and fault-set antecedents.
  wire fv = chan_in[0].frame_valid;
  wire fl = chan_in[0].send_fault_flag;
  wire rdy = link_ready[0];
  sdtx_code_out_t o;
  assign o = chan_out[0];
  // Every channel answers its own data slot.
  for (genvar c = 0; c < 4; c++) begin : g_ch
    chk_data_kind: assert property (
      link_ready[c] && chan_in[c].frame_valid && !chan_in[c].send_fault_flag
      |-> ##2 chan_out[c].kind == SDTX_DATA) else $error("data slot lost");
  end
  chk_error_code: assert property (
    rdy && fv && fl |-> ##2 o.kind == SDTX_ERROR && o.code inside {20'h1_785e, 20'he_87a1})
    else $error("bad error word");
  chk_extend_code: assert property (
    rdy && !fv && fl |-> ##2 o.kind == SDTX_EXTEND && o.code inside {20'h1_5c57, 20'he_a3a8})
    else $error("bad extend word");
  chk_idle_code: assert property (
    !fv && !fl |-> ##2 o.kind == SDTX_IDLE && o.code inside {20'ha_257c, 20'h6_9683}
    && !o.disp_pos) else $error("bad idle word");
  chk_start_run: assert property (
    $fell(reset) |-> (o.kind == SDTX_IDLE && !rdy)[*5] ##1 rdy) else $error("bad start run");
  chk_fault_set: assert property (
    rdy && fv && fl |-> ##2 frame_fault[0]) else $error("fault not flagged");
  chk_fault_clear: assert property (
    !fv |-> ##2 !frame_fault[0]) else $error("fault not cleared");
  chk_k_balance: assert property (
    o.kind inside {SDTX_EXTEND, SDTX_ERROR} |-> o.disp_pos == $past(o.disp_pos))
    else $error("k word moved disparity");
  cover property (o.kind == SDTX_ERROR);
  cover property (o.kind == SDTX_EXTEND);
  cover property ($rose(rdy));
endmodule

// ### testbench/sdtx_proto_dev.sv
`timescale 1ns/10ps
// Protocol device model; the bench calls drive just after a falling edge.
module sdtx_proto_dev
  import sdtx_pkg::*;
(
  output sdtx_word_in_t [3:0] chan
);
  initial chan = '0;
  // slot qualifiers
  // The caller holds frame-valid for the frame and drops it before the next edge.
  task automatic drive(input int ch, input logic fv, input logic fl, input logic [15:0] w);
    chan[ch].frame_valid = fv;
    chan[ch].send_fault_flag = fl;
    // Outside a slot the bus carries no word, so it toggles rather than holding stale data.
    chan[ch].send_word_bus = (fv || fl) ? w : ~chan[ch].send_word_bus;
  endtask
endmodule

// ### testbench/sdtx_word_port_tb_top.sv
`timescale 1ns/10ps
`define SDTX_CMP(nm, ex, gt) begin \
  cmp_count++; \
  if ((gt) !== (ex)) begin \
    err_total++; \
    $display("BAD %s expected %h seen %h", nm, ex, gt); \
  end \
end
module sdtx_word_port_tb_top
  import sdtx_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] factory_test_select = 4'h0;
  sdtx_word_in_t [3:0] chan_in;
  sdtx_code_out_t [3:0] chan_out;
  logic [3:0] frame_fault;
  logic [3:0] link_ready;
  int err_total = 0;
  int cmp_count = 0;
  sdtx_code_out_t exp_q [2][4];
  bit has_q [2][4];
  // Expected words, worked out by hand with bit 0 as the first line bit.
  localparam sdtx_code_out_t idle_n = '{SDTX_IDLE, 1'b0, 20'ha_257c};
  localparam sdtx_code_out_t idle_p = '{SDTX_IDLE, 1'b0, 20'h6_9683};
  localparam sdtx_code_out_t zero_w = '{SDTX_DATA, 1'b0, 20'h2_e4b9};
  localparam sdtx_code_out_t ext_n = '{SDTX_EXTEND, 1'b0, 20'h1_5c57};
  localparam sdtx_code_out_t err_n = '{SDTX_ERROR, 1'b0, 20'h1_785e};

  // Free-running word clock.
  always #5 clk = ~clk;

  sdtx_proto_dev sdtx_proto_dev_inst (.chan(chan_in));
  sdtx_word_port sdtx_word_port_inst (.clk, .reset, .chan_in, .factory_test_select,
    .chan_out, .frame_fault, .link_ready);

  // Queues one slot and its expected word two edges later.
  task automatic put(input int ch, input logic fv, input logic fl, input logic [15:0] w,
      input sdtx_code_out_t e);
    sdtx_proto_dev_inst.drive(ch, fv, fl, w);
    exp_q[0][ch] = e;
    has_q[0][ch] = 1'b1;
  endtask

  // One word clock; checks slots put two calls ago.
  task automatic tick();
    @(posedge clk);
    @(negedge clk);
    for (int c = 0; c < 4; c++) begin
      if (has_q[1][c]) `SDTX_CMP("chan_out", exp_q[1][c], chan_out[c])
      exp_q[1][c] = exp_q[0][c];
      has_q[1][c] = has_q[0][c];
      has_q[0][c] = 1'b0;
    end
  endtask

  // Reset, then a frame from the release on; commas come first, data once the run ends.
  // The frame is driven after the wait so the model's own start values cannot undo it.
  task automatic startup();
    has_q = '{default: 1'b0};
    reset = 1'b1;
    repeat (10) @(negedge clk);
    for (int c = 0; c < 4; c++) sdtx_proto_dev_inst.drive(c, 1'b1, 1'b0, 16'h0000);
    reset = 1'b0;
    for (int i = 1; i <= 6; i++) begin
      @(posedge clk);
      @(negedge clk);
      `SDTX_CMP("start word", (i < 5) ? idle_n : zero_w, chan_out[0])
      `SDTX_CMP("link_ready", (i >= 5) ? 4'hf : 4'h0, link_ready)
    end
    for (int c = 0; c < 4; c++) put(c, 1'b0, 1'b0, 16'h0000, idle_n);
    repeat (3) tick();
  endtask

  // Back-to-back data, byte order, disparity swing, then both idle forms.
  task automatic data_run();
    put(0, 1'b1, 1'b0, 16'hbcbc, '{SDTX_DATA, 1'b0, 20'h5_715c});
    tick();
    put(0, 1'b1, 1'b0, 16'h00bc, '{SDTX_DATA, 1'b0, 20'h2_e55c});
    tick();
    put(0, 1'b1, 1'b0, 16'h0020, '{SDTX_DATA, 1'b1, 20'hd_1a79});
    tick();
    put(0, 1'b0, 1'b0, 16'h0000, idle_p);
    tick();
    put(0, 1'b0, 1'b0, 16'h0000, idle_n);
    repeat (3) tick();
  endtask

  // Extension, error mid-frame, and the fault flag lifetime.
  task automatic fault_run();
    put(0, 1'b0, 1'b1, 16'h1234, ext_n);
    tick();
    put(0, 1'b1, 1'b1, 16'h5678, err_n);
    tick();
    put(0, 1'b1, 1'b0, 16'h0000, zero_w);
    tick();
    `SDTX_CMP("fault set", 1'b1, frame_fault[0])
    put(0, 1'b0, 1'b0, 16'h0000, idle_n);
    tick();
    `SDTX_CMP("fault held", 1'b1, frame_fault[0])
    tick();
    `SDTX_CMP("fault clear", 1'b0, frame_fault[0])
    tick();
  endtask

  // Four channels, four different slot kinds in the same cycle.
  task automatic chan_run();
    put(0, 1'b1, 1'b0, 16'h0000, zero_w);
    put(1, 1'b0, 1'b1, 16'h0000, ext_n);
    put(2, 1'b1, 1'b1, 16'h0000, err_n);
    put(3, 1'b0, 1'b0, 16'h0000, idle_n);
    repeat (2) tick();
    `SDTX_CMP("fault lanes", 4'h4, frame_fault)
    for (int c = 0; c < 3; c++) put(c, 1'b0, 1'b0, 16'h0000, idle_n);
    repeat (3) tick();
  endtask

  // Single place where the run ends.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence, with a second reset in mid-run.
  initial begin
    startup();
    data_run();
    fault_run();
    chan_run();
    startup();
    data_run();
    end_sim();
  end

  // Guards against a hang.
  initial begin
    #100us;
    err_total++;
    end_sim();
  end
endmodule
bind sdtx_word_port sdtx_word_port_chk sdtx_word_port_chk_inst (.clk, .reset, .chan_in,
  .factory_test_select, .chan_out, .frame_fault, .link_ready);
